// ### rtl/sosc_pkg.sv
/*
 * Shared constants and types for the servo overtravel and stop control block:
 * register offsets, field positions, reset values, timing counts and the
 * encodings of stop causes, stop methods and post-stop states.
 * Assumes a single 100 MHz clock and a 32-bit APB register bus.
 */
package sosc_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Limit input filtering: a level must stand this long before it is taken
    localparam int LIM_DEB_TIME_NS = 20000;
    localparam int LIM_DEB_CYCLES = (LIM_DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LIM_DEB_W = 12;

    // Register byte offsets
    localparam logic [11:0] CFG_OFS = 12'h000;
    localparam logic [11:0] CTRL_OFS = 12'h004;
    localparam logic [11:0] TRQ_OFS = 12'h008;
    localparam logic [11:0] STAT_OFS = 12'h00C;
    localparam logic [11:0] ACT_OFS = 12'h010;

    // Configuration word fields (restart-latched)
    localparam int FWD_DIS_BIT = 0;
    localparam int REV_DIS_BIT = 1;
    localparam int C1_SEL_LSB = 2;
    localparam int LIM_SEL_LSB = 4;
    localparam int C2_SEL_LSB = 6;
    localparam int DIR_INV_BIT = 9;
    localparam int SUP_SEL_LSB = 10;
    localparam int PIN_ALLOC_LSB = 12;
    localparam int CFG_W = 20;
    localparam logic [CFG_W-1:0] CFG_RST = 20'h2_1000;

    // Pin allocation slot codes
    localparam logic [3:0] ALLOC_FWD = 4'h1;
    localparam logic [3:0] ALLOC_REV = 4'h2;

    // Control word fields
    localparam int RESTART_BIT = 0;

    // Reverse brake torque, percent of rated
    localparam int TRQ_W = 9;
    localparam logic [TRQ_W-1:0] TRQ_RST = 9'h12C;
    localparam logic [TRQ_W-1:0] TRQ_MAX = 9'h15E;

    // Supply type codes
    localparam logic [1:0] SUP_SINGLE = 2'h0;
    localparam logic [1:0] SUP_THREE = 2'h1;
    localparam logic [1:0] SUP_DC = 2'h2;

    // Stop selection codes with a fixed meaning
    localparam logic [2:0] C2_NO_STOP = 3'h5;

    typedef enum logic [1:0] {
        CS_NONE = 2'b00,
        CS_CLASS1 = 2'b01,
        CS_CLASS2 = 2'b11,
        CS_OT = 2'b10
    } sosc_cause_t;

    typedef enum logic [1:0] {
        SM_DYN_BRAKE = 2'b00,
        SM_COAST = 2'b01,
        SM_REV_BRAKE = 2'b11,
        SM_NO_STOP = 2'b10
    } sosc_method_t;

    typedef enum logic [1:0] {
        PS_COAST = 2'b00,
        PS_DYN_BRAKE = 2'b01,
        PS_ZERO_CLAMP = 2'b11,
        PS_OPERATE = 2'b10
    } sosc_post_t;

    typedef enum logic [1:0] {
        PH_RUN = 2'b00,
        PH_STOPPING = 2'b01,
        PH_STOPPED = 2'b11
    } sosc_phase_t;

endpackage

// ### rtl/sosc_limit_filter.sv
/*
 * Synchroniser and debounce filter for the two travel-limit pins.
 * Assumes raw pins are asynchronous to ref_clk; outputs are clean levels.
 */
`timescale 1ns/10ps
module sosc_limit_filter (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [1:0] raw_in,
    output logic [1:0] clean_out
);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            logic s1_r, s2_r, s3_r;
            logic [sosc_pkg::LIM_DEB_W-1:0] cnt_r;

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else if (ce) begin
                    s1_r <= raw_in[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end

            // Take a new level only after it has stood for the whole window
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_r <= '0;
                    clean_out[gi] <= 1'b0;
                end else if (ce) begin
                    if (s2_r != s3_r || s3_r == clean_out[gi]) begin
                        cnt_r <= '0;
                    end else if (cnt_r == sosc_pkg::LIM_DEB_W'(sosc_pkg::LIM_DEB_CYCLES - 1)) begin
                        cnt_r <= '0;
                        clean_out[gi] <= s3_r;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule

// ### rtl/sosc_stop_decode.sv
/*
 * Maps the active stop cause and the latched selection codes to a stop
 * method and a post-stop state. Purely combinational.
 */
`timescale 1ns/10ps
module sosc_stop_decode (
    input sosc_pkg::sosc_cause_t cause,
    input wire logic [1:0] class1_stop_sel,
    input wire logic [1:0] limit_stop_sel,
    input wire logic [2:0] class2_stop_sel,
    output sosc_pkg::sosc_method_t method,
    output sosc_pkg::sosc_post_t post
);

    always_comb begin
        method = sosc_pkg::SM_DYN_BRAKE;
        post = sosc_pkg::PS_COAST;
        unique case (cause)
            sosc_pkg::CS_NONE: begin
                method = sosc_pkg::SM_NO_STOP;
                post = sosc_pkg::PS_OPERATE;
            end
            sosc_pkg::CS_CLASS1: begin
                case (class1_stop_sel)
                    2'h1: post = sosc_pkg::PS_DYN_BRAKE;
                    2'h2: method = sosc_pkg::SM_COAST;
                    default: ;
                endcase
            end
            sosc_pkg::CS_OT: begin
                case (limit_stop_sel)
                    2'h1: method = sosc_pkg::SM_COAST;
                    2'h2: begin
                        method = sosc_pkg::SM_REV_BRAKE;
                        post = sosc_pkg::PS_ZERO_CLAMP;
                    end
                    2'h3: method = sosc_pkg::SM_REV_BRAKE;
                    default: ;
                endcase
            end
            sosc_pkg::CS_CLASS2: begin
                case (class2_stop_sel)
                    3'h1: post = sosc_pkg::PS_DYN_BRAKE;
                    3'h2: method = sosc_pkg::SM_COAST;
                    3'h3: begin
                        method = sosc_pkg::SM_REV_BRAKE;
                        post = sosc_pkg::PS_DYN_BRAKE;
                    end
                    3'h4: method = sosc_pkg::SM_REV_BRAKE;
                    3'h5: begin
                        method = sosc_pkg::SM_NO_STOP;
                        post = sosc_pkg::PS_OPERATE;
                    end
                    default: ;
                endcase
            end
        endcase
    end

endmodule

// ### rtl/sosc_stop_ctrl.sv
/*
 * Stop control for one servo axis: travel-limit supervision, stop sequencing,
 * reverse-brake torque limit, rotation sense and supply-type check, with an
 * APB register slave. Assumes drive events and speed feedback arrive on
 * ref_clk; the limit pins are asynchronous.
 */
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
// What this block does
// - Forward limit ON allows forward motion; OFF means forward overtravel, forward prohibited.
// - Reverse limit ON allows reverse motion; OFF means reverse overtravel, reverse prohibited.
// - fwd_limit_disable 1 ignores forward limit; takes effect after restart.
// - rev_limit_disable 1 ignores reverse limit; takes effect after restart.
// - Without pin codes 1 or 2 allocated, the overtravel function is off.
// - Alarms, overtravel or servo off stop the motor by one of four methods.
// - No-stop method turns the alarm into a warning and keeps driving.
// - After stopping, hold coasting, dynamic brake, zero clamp or operation.
// - class1_stop_sel codes 0..2 choose method and post state for class-one stops.
// - limit_stop_sel codes 0..3 choose method and post state for overtravel.
// - Reverse braking forces speed reference zero, skips soft start, limits torque.
// - class2_stop_sel codes 0..5 choose method and post state for class-two alarms.
// - class2 codes 3 or 4 decelerate with torque capped by rev_brake_torque.
// - rev_brake_torque is 0..350 percent, default 300, immediate, capped by motor.
// - dir_invert reverses commanded rotation; default forward is counterclockwise.
// - supply_type_sel 0 single-phase, 1 three-phase, after restart.
// - Detected supply differing from supply_type_sel, with code 1 read as single-phase on low ratings, raises supply_wiring_alarm.
module sosc_stop_ctrl (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fwd_limit_in,
    input wire logic rev_limit_in,
    input wire logic alarm_class_one,
    input wire logic alarm_class_two,
    input wire logic safety_state,
    input wire logic servo_on,
    input wire logic speed_zero,
    input wire logic cmd_dir_fwd,
    input wire logic [8:0] motor_max_torque,
    input wire logic [1:0] supply_detect,
    input wire logic low_power_rating,
    output logic fwd_allow,
    output logic rev_allow,
    output logic drive_enable,
    output logic dyn_brake,
    output logic zero_clamp,
    output logic speed_ref_zero,
    output logic torque_limit_en,
    output logic [8:0] torque_limit,
    output logic motor_dir_cw,
    output logic stop_warning,
    output logic supply_wiring_alarm
);

    logic [sosc_pkg::CFG_W-1:0] cfg_r;
    logic [sosc_pkg::CFG_W-1:0] cfg_act_r;
    logic [sosc_pkg::TRQ_W-1:0] trq_r;
    logic [sosc_pkg::TRQ_W-1:0] trq_nxt;
    logic [1:0] lim_clean;
    logic fwd_used, rev_used, fwd_ot, rev_ot;
    logic [3:0] slot0, slot1;
    sosc_pkg::sosc_cause_t cause;
    sosc_pkg::sosc_method_t method, method_r;
    sosc_pkg::sosc_post_t post, post_r;
    sosc_pkg::sosc_phase_t phase_r, phase_nxt;
    logic wr_en, rd_setup, addr_ok;
    logic [31:0] rd_nxt;
    logic [1:0] sup_sel;
    logic sup_mismatch;

    sosc_limit_filter u_filter (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .raw_in({rev_limit_in, fwd_limit_in}),
        .clean_out(lim_clean)
    );

    // APB slave: zero wait states, frozen with the clock enable
    assign pready = ce;
    assign wr_en = psel && penable && pwrite && ce;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok = (paddr == sosc_pkg::CFG_OFS) || (paddr == sosc_pkg::CTRL_OFS) ||
        (paddr == sosc_pkg::TRQ_OFS) || (paddr == sosc_pkg::STAT_OFS) || (paddr == sosc_pkg::ACT_OFS);
    assign pslverr = psel && penable && !addr_ok;

    // Staged configuration; the live copy only changes at reset or restart
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= sosc_pkg::CFG_RST;
        end else if (wr_en && paddr == sosc_pkg::CFG_OFS) begin
            cfg_r <= pwdata[sosc_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_act_r <= sosc_pkg::CFG_RST;
        end else if (wr_en && paddr == sosc_pkg::CTRL_OFS && pwdata[sosc_pkg::RESTART_BIT]) begin
            cfg_act_r <= cfg_r;
        end
    end

    // Torque limit writes clamp to the allowed range and apply at once
    always_comb begin
        trq_nxt = pwdata[sosc_pkg::TRQ_W-1:0];
        if (pwdata[31:0] > 32'(sosc_pkg::TRQ_MAX)) begin
            trq_nxt = sosc_pkg::TRQ_MAX;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            trq_r <= sosc_pkg::TRQ_RST;
        end else if (wr_en && paddr == sosc_pkg::TRQ_OFS) begin
            trq_r <= trq_nxt;
        end
    end

    // Limit supervision
    assign slot0 = cfg_act_r[sosc_pkg::PIN_ALLOC_LSB +: 4];
    assign slot1 = cfg_act_r[sosc_pkg::PIN_ALLOC_LSB + 4 +: 4];
    assign fwd_used = !cfg_act_r[sosc_pkg::FWD_DIS_BIT] &&
        (slot0 == sosc_pkg::ALLOC_FWD || slot1 == sosc_pkg::ALLOC_FWD);
    assign rev_used = !cfg_act_r[sosc_pkg::REV_DIS_BIT] &&
        (slot0 == sosc_pkg::ALLOC_REV || slot1 == sosc_pkg::ALLOC_REV);
    assign fwd_ot = fwd_used && !lim_clean[0];
    assign rev_ot = rev_used && !lim_clean[1];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fwd_allow <= 1'b0;
            rev_allow <= 1'b0;
        end else if (ce) begin
            fwd_allow <= !fwd_ot;
            rev_allow <= !rev_ot;
        end
    end

    // Alarms outrank the safety state, servo off and overtravel
    always_comb begin
        if (alarm_class_one) begin
            cause = sosc_pkg::CS_CLASS1;
        end else if (alarm_class_two) begin
            cause = sosc_pkg::CS_CLASS2;
        end else if (safety_state || !servo_on) begin
            cause = sosc_pkg::CS_CLASS1;
        end else if (fwd_ot || rev_ot) begin
            cause = sosc_pkg::CS_OT;
        end else begin
            cause = sosc_pkg::CS_NONE;
        end
    end

    sosc_stop_decode u_decode (
        .cause(cause),
        .class1_stop_sel(cfg_act_r[sosc_pkg::C1_SEL_LSB +: 2]),
        .limit_stop_sel(cfg_act_r[sosc_pkg::LIM_SEL_LSB +: 2]),
        .class2_stop_sel(cfg_act_r[sosc_pkg::C2_SEL_LSB +: 3]),
        .method(method),
        .post(post)
    );

    // Stop sequencer
    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            sosc_pkg::PH_RUN: begin
                if (method != sosc_pkg::SM_NO_STOP) begin
                    phase_nxt = sosc_pkg::PH_STOPPING;
                end
            end
            sosc_pkg::PH_STOPPING: begin
                if (method == sosc_pkg::SM_NO_STOP) begin
                    phase_nxt = sosc_pkg::PH_RUN;
                end else if (speed_zero) begin
                    phase_nxt = sosc_pkg::PH_STOPPED;
                end
            end
            sosc_pkg::PH_STOPPED: begin
                if (method == sosc_pkg::SM_NO_STOP) begin
                    phase_nxt = sosc_pkg::PH_RUN;
                end
            end
            default: phase_nxt = sosc_pkg::PH_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= sosc_pkg::PH_RUN;
            method_r <= sosc_pkg::SM_NO_STOP;
            post_r <= sosc_pkg::PS_OPERATE;
        end else if (ce) begin
            phase_r <= phase_nxt;
            method_r <= method;
            post_r <= post;
        end
    end

    // Power stage and speed loop commands
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            drive_enable <= 1'b0;
            dyn_brake <= 1'b0;
            zero_clamp <= 1'b0;
            speed_ref_zero <= 1'b0;
            torque_limit_en <= 1'b0;
        end else if (ce) begin
            drive_enable <= 1'b0;
            dyn_brake <= 1'b0;
            zero_clamp <= 1'b0;
            speed_ref_zero <= 1'b0;
            torque_limit_en <= 1'b0;
            unique case (phase_nxt)
                sosc_pkg::PH_RUN: drive_enable <= servo_on && !safety_state;
                sosc_pkg::PH_STOPPING: begin
                    if (method == sosc_pkg::SM_DYN_BRAKE) begin
                        dyn_brake <= 1'b1;
                    end else if (method == sosc_pkg::SM_REV_BRAKE) begin
                        drive_enable <= 1'b1;
                        speed_ref_zero <= 1'b1;
                        torque_limit_en <= 1'b1;
                    end
                end
                sosc_pkg::PH_STOPPED: begin
                    if (post == sosc_pkg::PS_DYN_BRAKE) begin
                        dyn_brake <= 1'b1;
                    end else if (post == sosc_pkg::PS_ZERO_CLAMP) begin
                        drive_enable <= 1'b1;
                        zero_clamp <= 1'b1;
                    end else if (post == sosc_pkg::PS_OPERATE) begin
                        drive_enable <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            torque_limit <= sosc_pkg::TRQ_RST;
            stop_warning <= 1'b0;
            motor_dir_cw <= 1'b0;
        end else if (ce) begin
            torque_limit <= (trq_r < motor_max_torque) ? trq_r : motor_max_torque;
            stop_warning <= (cause == sosc_pkg::CS_CLASS2) &&
                (cfg_act_r[sosc_pkg::C2_SEL_LSB +: 3] == sosc_pkg::C2_NO_STOP);
            motor_dir_cw <= !cmd_dir_fwd ^ cfg_act_r[sosc_pkg::DIR_INV_BIT];
        end
    end

    // Supply check; three-phase code is void on low ratings
    assign sup_sel = cfg_act_r[sosc_pkg::SUP_SEL_LSB +: 2];
    always_comb begin
        if (sup_sel == sosc_pkg::SUP_THREE && low_power_rating) begin
            sup_mismatch = supply_detect != sosc_pkg::SUP_SINGLE;
        end else begin
            sup_mismatch = supply_detect != sup_sel;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            supply_wiring_alarm <= 1'b0;
        end else if (ce) begin
            supply_wiring_alarm <= sup_mismatch;
        end
    end

    // Read data is captured in the setup cycle
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (paddr)
            sosc_pkg::CFG_OFS: rd_nxt[sosc_pkg::CFG_W-1:0] = cfg_r;
            sosc_pkg::TRQ_OFS: rd_nxt[sosc_pkg::TRQ_W-1:0] = trq_r;
            sosc_pkg::STAT_OFS: rd_nxt[11:0] = {supply_wiring_alarm, stop_warning, post_r, method_r,
                phase_r, rev_ot, fwd_ot, lim_clean};
            sosc_pkg::ACT_OFS: rd_nxt[sosc_pkg::CFG_W-1:0] = cfg_act_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && rd_setup) begin
            prdata <= rd_nxt;
        end
    end

endmodule

// ### tb/sosc_stop_ctrl_assertions.sv
/* Checker bound to the stop control top module.
   Assumes ce held high and one clock domain. */
`timescale 1ns/10ps
module sosc_stop_ctrl_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic fwd_limit_in,
    input wire logic alarm_class_one,
    input wire logic safety_state,
    input wire logic servo_on,
    input wire logic cmd_dir_fwd,
    input wire logic [8:0] motor_max_torque,
    input wire logic fwd_allow,
    input wire logic drive_enable,
    input wire logic dyn_brake,
    input wire logic zero_clamp,
    input wire logic speed_ref_zero,
    input wire logic torque_limit_en,
    input wire logic [8:0] torque_limit,
    input wire logic motor_dir_cw,
    input wire logic stop_warning
);
    logic prev_fwd_r;
    logic [11:0] quiet_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Cycles the forward pin has held its present level
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prev_fwd_r <= 1'h0;
            quiet_r <= 12'h000;
        end else begin
            prev_fwd_r <= fwd_limit_in;
            quiet_r <= (fwd_limit_in != prev_fwd_r) ? 12'h000 : quiet_r + {11'h000, quiet_r != 12'hFFF};
        end
    end
    AST_C1_STOP: assert property (alarm_class_one |=> !drive_enable && !stop_warning)
        else $error("class-one alarm left the drive on");
    AST_SAFE_STOP: assert property (safety_state |=> !drive_enable)
        else $error("safety state left the drive on");
    AST_SERVO_OFF: assert property (!servo_on |=> !drive_enable && !speed_ref_zero)
        else $error("servo off left the drive on");
    AST_DB_HOLD: assert property (dyn_brake |-> !drive_enable && !zero_clamp)
        else $error("dynamic brake while driving");
    AST_CLAMP: assert property (zero_clamp |-> drive_enable && !dyn_brake)
        else $error("zero clamp without position loop");
    AST_RB_REF: assert property (speed_ref_zero |-> torque_limit_en && drive_enable)
        else $error("reverse brake without torque limit");
    AST_TRQ_CAP: assert property (torque_limit <= 9'h15E && torque_limit <= $past(motor_max_torque))
        else $error("torque limit above cap");
    AST_DIR: assert property ($changed(cmd_dir_fwd) |=> $changed(motor_dir_cw))
        else $error("direction change not followed");
    AST_FWD_DEB: assert property ($fell(fwd_allow) |-> !fwd_limit_in && quiet_r >= 12'd2000)
        else $error("forward stop without settled pin");
    AST_NOSTOP: assert property (stop_warning && $past(servo_on) && !$past(safety_state)
        && !$past(alarm_class_one) |-> drive_enable && !dyn_brake)
        else $error("no-stop warning stopped the motor");
    COV_RB_CLAMP: cover property (speed_ref_zero ##1 zero_clamp);
    COV_WARN: cover property (stop_warning);
    COV_FWD_OT: cover property ($fell(fwd_allow));
endmodule

bind sosc_stop_ctrl sosc_stop_ctrl_chk u_chk (.*);

// ### tb/sosc_limit_model.sv
/* Limit switches and motor load seen by the stop control block.
   Assumes the bench commands end-of-travel hits on ref_clk. */
`timescale 1ns/10ps
module sosc_limit_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic fwd_hit,
    input wire logic rev_hit,
    input wire logic drive_enable,
    input wire logic speed_ref_zero,
    input wire logic zero_clamp,
    output logic fwd_limit_in,
    output logic rev_limit_in,
    output logic speed_zero
);
    logic [4:0] coast_r;
    // Normally closed switches open at the end of travel
    assign fwd_limit_in = !fwd_hit;
    assign rev_limit_in = !rev_hit;
    // Motor comes to rest a fixed time after it stops being driven
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            coast_r <= 5'h00;
        end else if (drive_enable && !speed_ref_zero && !zero_clamp) begin
            coast_r <= 5'h00;
        end else if (coast_r != 5'h14) begin
            coast_r <= coast_r + 5'h01;
        end
    end
    assign speed_zero = (coast_r == 5'h14);
endmodule

// ### tb/tb_servo_overtravel_stop_control.sv
/* Self-checking bench for the stop control block over APB.
   Assumes the limit model and the bound checker. */
`timescale 1ns/10ps
module tb_servo_overtravel_stop_control;
    logic ref_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fwd_hit = 1'h0, rev_hit = 1'h0;
    logic alarm_class_one = 1'h0, alarm_class_two = 1'h0, safety_state = 1'h0, low_power_rating = 1'h0;
    logic ce = 1'h1, servo_on = 1'h1, cmd_dir_fwd = 1'h1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [8:0] motor_max_torque = 9'h1FF;
    logic [1:0] supply_detect = 2'h0;
    logic [31:0] prdata, rdat;
    logic [8:0] torque_limit;
    logic pready, pslverr, rerr, fwd_limit_in, rev_limit_in, speed_zero, fwd_allow, rev_allow;
    logic drive_enable, dyn_brake, zero_clamp, speed_ref_zero, torque_limit_en, motor_dir_cw;
    logic stop_warning, supply_wiring_alarm;
    int error_cnt = 0;
    int cmp_count = 0;
    wire [5:0] ov = {drive_enable, dyn_brake, zero_clamp, speed_ref_zero, torque_limit_en, stop_warning};
    // kind, code, vector while stopping, vector after stopping
    localparam logic [17:0] TBL [17] = '{18'h0_8400, 18'h0_9410, 18'h0_A000, 18'h1_0400, 18'h1_1410,
        18'h1_2000, 18'h1_3990, 18'h1_4980, 18'h1_5861, 18'h1_8400, 18'h1_9000, 18'h1_A9A8, 18'h1_B980,
        18'h2_29A8, 18'h2_9410, 18'h3_2000, 18'h1_0400};
    sosc_stop_ctrl dut (.ref_clk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fwd_limit_in, .rev_limit_in, .alarm_class_one, .alarm_class_two, .safety_state, .servo_on,
        .speed_zero, .cmd_dir_fwd, .motor_max_torque, .supply_detect, .low_power_rating, .fwd_allow, .rev_allow,
        .drive_enable, .dyn_brake, .zero_clamp, .speed_ref_zero, .torque_limit_en, .torque_limit,
        .motor_dir_cw, .stop_warning, .supply_wiring_alarm);
    sosc_limit_model partner (.ref_clk, .nrst, .fwd_hit, .rev_hit, .drive_enable, .speed_ref_zero, .zero_clamp,
        .fwd_limit_in, .rev_limit_in, .speed_zero);
    always #5 ref_clk = !ref_clk;
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic nap(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic cfg(input logic [31:0] v);
        apb(1'h1, sosc_pkg::CFG_OFS, v);
        apb(1'h1, sosc_pkg::CTRL_OFS, 32'h1);
        nap(3);
    endtask
    task automatic cause(input logic [2:0] k, input logic v);
        @(posedge ref_clk);
        case (k)
            3'h1: alarm_class_one <= v;
            3'h2: alarm_class_two <= v;
            3'h3: fwd_hit <= v;
            3'h4: rev_hit <= v;
            3'h5: safety_state <= v;
            default: servo_on <= !v;
        endcase
    endtask
    task automatic wait_ov(input logic [5:0] v, input logic eq);
        for (int n = 0; n < 3000 && ((ov === v) != eq); n++) @(negedge ref_clk);
    endtask
    initial begin
        repeat (60_000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        logic [17:0] e;
        int lsb;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'h1;
        apb(1'h0, sosc_pkg::CFG_OFS, 32'h0);
        chk("cfg", 32'h0002_1000, rdat);
        apb(1'h0, sosc_pkg::ACT_OFS, 32'h0);
        chk("act", 32'h0002_1000, rdat);
        apb(1'h0, sosc_pkg::TRQ_OFS, 32'h0);
        chk("trq", 32'h0000_012C, rdat);
        apb(1'h0, 12'h020, 32'h0);
        chk("err", 32'h1, 32'(rerr));
        apb(1'h1, sosc_pkg::TRQ_OFS, 32'h0000_01FF);
        apb(1'h0, sosc_pkg::TRQ_OFS, 32'h0);
        chk("trq_clamp", 32'h0000_015E, rdat);
        motor_max_torque <= 9'h0C8;
        nap(3);
        chk("trq_motor", 32'h0000_00C8, 32'(torque_limit));
        chk("dir_fwd", 32'h0, 32'(motor_dir_cw));
        chk("sup_ok", 32'h0, 32'(supply_wiring_alarm));
        @(posedge ref_clk);
        motor_max_torque <= 9'h1FF;
        cmd_dir_fwd <= 1'h0;
        supply_detect <= 2'h1;
        nap(3);
        chk("dir_rev", 32'h1, 32'(motor_dir_cw));
        chk("sup_bad", 32'h1, 32'(supply_wiring_alarm));
        cfg(32'h0002_1600);
        chk("dir_inv", 32'h0, 32'(motor_dir_cw));
        chk("sup_three", 32'h0, 32'(supply_wiring_alarm));
        @(posedge ref_clk);
        low_power_rating <= 1'h1;
        nap(3);
        chk("sup_low", 32'h1, 32'(supply_wiring_alarm));
        cfg(32'h0002_1800);
        @(posedge ref_clk);
        supply_detect <= 2'h2;
        nap(3);
        chk("sup_dc", 32'h0, 32'(supply_wiring_alarm));
        @(posedge ref_clk);
        supply_detect <= 2'h0;
        low_power_rating <= 1'h0;
        apb(1'h1, sosc_pkg::CFG_OFS, 32'h0002_1003);
        apb(1'h0, sosc_pkg::ACT_OFS, 32'h0);
        chk("staged", 32'h0002_1800, rdat);
        for (int p = 0; p < 2; p++) begin
            cfg(p == 0 ? 32'h0002_1003 : 32'h0);
            @(posedge ref_clk);
            fwd_hit <= 1'h1;
            rev_hit <= 1'h1;
            nap(2100);
            chk("lim_off", 32'h8000_0003, {ov, 24'h0, fwd_allow, rev_allow});
            @(posedge ref_clk);
            fwd_hit <= 1'h0;
            rev_hit <= 1'h0;
        end
        nap(2100);
        for (int i = 0; i < 17; i++) begin
            e = TBL[i];
            lsb = (e[17:15] == 3'h2) ? 6 : (e[17:15] == 3'h3 || e[17:15] == 3'h4) ? 4 : 2;
            cfg(32'h0002_1000 | (32'(e[14:12]) << lsb));
            cause(e[17:15], 1'h1);
            wait_ov(6'h20, 1'h0);
            chk("stop", 32'(e[11:6]), 32'(ov));
            chk("allow", (e[17:15] == 3'h3) ? 32'h1 : (e[17:15] == 3'h4) ? 32'h2 : 32'h3,
                {30'h0, fwd_allow, rev_allow});
            nap(30);
            chk("post", 32'(e[5:0]), 32'(ov));
            cause(e[17:15], 1'h0);
            wait_ov(6'h20, 1'h1);
            chk("run", 32'h0000_0020, 32'(ov));
        end
        wrap_up();
    end
endmodule
